/* File: hw/ddrh_pkg.sv */
// Operation
// RQ1 - Clock gate high runs module clocks; low enters power-down or self-refresh.
// RQ2 - Rank select high makes the module ignore new commands.
// RQ3 - Address and control are captured on the rising true clock edge.
// RQ4 - RAS, CAS and WE levels together select the operation.
// RQ5 - Two bank-address lines pick the bank a command acts on.
// RQ6 - Activate carries the thirteen-bit row address.
// RQ7 - Read and write carry the column address on low address lines.
// RQ8 - AP high with read or write auto-precharges the bank after burst.
// RQ9 - Precharge with AP high closes all four banks.
// RQ10 - Precharge with AP low closes only the addressed bank.
// RQ11 - Module drives read strobes edge aligned with read data.
// RQ12 - Controller drives write strobes centred in the data eye.
// RQ13 - Each mask bit high discards its write byte, low stores it.
// RQ14 - Masks have no effect during reads.
// RQ15 - Mode register must be programmed before any access.
// RQ16 - CAS latency is two and a half or three cycles.
// RQ17 - Burst length is two, four or eight.
// RQ18 - Burst order is sequential or interleaved.
// RQ19 - Auto-refresh average spacing must stay within the maximum interval.
// RQ20 - Data moves on both clock edges, two per cycle.
// RQ21 - Module clock runs at up to the rated frequency.
// RQ22 - Command codes follow the standard DDR command truth table.
package ddrh_pkg;
  // ***********************************************************
  // Wishbone register map
  // ***********************************************************
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_MODE   = 8'h04;
  localparam logic [7:0] REG_ADDR   = 8'h08;
  localparam logic [7:0] REG_WDATA  = 8'h0c;
  localparam logic [7:0] REG_RDATA  = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_WMASK  = 8'h18;
  // Control fields
  localparam int CTRL_GO      = 0;
  localparam int CTRL_CMD_LSB = 1;
  localparam int CTRL_AP      = 4;
  localparam int CTRL_CKE     = 5;
  localparam int CTRL_RFEN    = 6;
  localparam logic [31:0] CTRL_RST_VAL = 32'h0000_0000;
  localparam logic [31:0] MODE_RST_VAL = 32'h0000_0000;
  // Mode register word layout on address pins
  localparam int MR_BL_LSB = 0;
  localparam int MR_BT     = 3;
  localparam int MR_CL_LSB = 4;
  // ***********************************************************
  // Command encodings {ras_n, cas_n, we_n}
  // ***********************************************************
  localparam logic [2:0] CMD_NOP  = 3'h7;
  localparam logic [2:0] CMD_ACT  = 3'h3;
  localparam logic [2:0] CMD_RD   = 3'h5;
  localparam logic [2:0] CMD_WR   = 3'h4;
  localparam logic [2:0] CMD_PRE  = 3'h2;
  localparam logic [2:0] CMD_REF  = 3'h1;
  localparam logic [2:0] CMD_MRS  = 3'h0;
  // Software command codes
  localparam logic [2:0] OP_ACT = 3'h0;
  localparam logic [2:0] OP_RD  = 3'h1;
  localparam logic [2:0] OP_WR  = 3'h2;
  localparam logic [2:0] OP_PRE = 3'h3;
  localparam logic [2:0] OP_REF = 3'h4;
  localparam logic [2:0] OP_MRS = 3'h5;
  // ***********************************************************
  // Timing
  // ***********************************************************
  localparam int CLK_PERIOD_PS  = 4000;
  localparam int REFI_MAX_NS    = 7800;
  localparam int REFI_CYC       = REFI_MAX_NS * 1000 / CLK_PERIOD_PS;
  localparam int LINK_DIV       = 2;   // link clock = 1/(2*DIV) of sys
  localparam int CMD_GAP_CYC    = 24;  // link cycles spare between cmds
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_CMD  = 5'b00010,
    ST_WAIT = 5'b00100,
    ST_DATA = 5'b01000,
    ST_DONE = 5'b10000
  } ddrh_state_e;
endpackage

/* File: hw/ddrh_div.sv */
`timescale 1ns/100ps
module ddrh_div
  import ddrh_pkg::*;
#(
  parameter int DIV = LINK_DIV
)(
  input  wire logic I_CLK,     // system clock
  input  wire logic I_SYS_RST, // sync reset
  output logic      o_rise,    // pulse: link clock rises next
  output logic      o_fall,    // pulse: link clock falls next
  output logic      o_ck       // link clock level
);
  if (DIV < 2 || DIV > 256) $error("DIV out of range");
  logic [7:0] cnt_ff;
  always_ff @(posedge I_CLK)
  begin
    if (I_SYS_RST)
    begin
      cnt_ff <= 8'h00;
      o_ck   <= 1'b0;
    end
    else if (cnt_ff == 8'(DIV - 1))
    begin
      cnt_ff <= 8'h00;
      o_ck   <= ~o_ck;
    end
    else
      cnt_ff <= cnt_ff + 8'h01;
  end
  always_comb
  begin
    o_rise = (cnt_ff == 8'(DIV - 1)) && !o_ck;
    o_fall = (cnt_ff == 8'(DIV - 1)) && o_ck;
  end
endmodule

/* File: hw/ddrh_ctrl.sv */
// Added by the designer: the Wishbone interface to the registers and the address map.
`timescale 1ns/100ps
module ddrh_ctrl
  import ddrh_pkg::*;
#(
  parameter int REFI = REFI_CYC
)(
  input  wire logic        I_CLK,        // system clock 250 MHz
  input  wire logic        I_SYS_RST,    // sync reset, active high
  input  wire logic        I_WB_CYC,     // wishbone cycle
  input  wire logic        I_WB_STB,     // wishbone strobe
  input  wire logic        I_WB_WE,      // wishbone write
  input  wire logic [7:0]  I_WB_ADR,     // byte address
  input  wire logic [3:0]  I_WB_SEL,     // byte lanes
  input  wire logic [31:0] I_WB_DAT,     // write data
  output logic      [31:0] O_WB_DAT,     // read data
  output logic             O_WB_ACK,     // ack
  output logic             O_CK,         // link clock true
  output logic             O_CK_N,       // link clock complement
  output logic             O_CLOCK_GATE, // clock gate to module
  output logic             O_RANK_SEL_N, // rank select, low active
  output logic             O_RAS_N,      // row strobe
  output logic             O_CAS_N,      // column strobe
  output logic             O_WE_N,       // write enable
  output logic      [1:0]  O_BA,         // bank address
  output logic      [12:0] O_A,          // address, A10 is AP
  output logic      [7:0]  O_DQ,         // data out (byte 0 lane)
  output logic             O_DQ_OE,      // data drive enable
  input  wire logic [7:0]  I_DQ,         // data in
  output logic             O_DQS,        // strobe out
  output logic             O_DQS_OE,     // strobe drive enable
  input  wire logic        I_DQS,        // strobe in
  output logic             O_DM          // write mask
);
  if (REFI <= 2 * CMD_GAP_CYC * LINK_DIV || REFI > 65535) $error("bad REFI");

  // ***********************************************************
  // Registers
  // ***********************************************************
  logic [31:0] ctrl_ff, mode_ff, addr_ff, wdata_ff, rdata_ff;
  logic [3:0]  wmask_ff;
  logic        busy_ff, mrs_done_ff, err_ff;
  logic [15:0] ref_cnt_ff;
  logic        ref_pend_ff;
  logic        go;
  logic        rise, fall, ck, dqs_edge;
  ddrh_state_e state_ff;
  logic [2:0]  op_ff;
  logic [7:0]  wait_ff;
  logic [3:0]  beat_ff;
  logic [3:0]  burst_len;
  logic [1:0]  dq_sync_ff [2];
  logic [7:0]  dq_s1_ff, dq_s2_ff;

  ddrh_div #(.DIV(LINK_DIV)) u_div (
    .I_CLK     (I_CLK),
    .I_SYS_RST (I_SYS_RST),
    .o_rise    (rise),
    .o_fall    (fall),
    .o_ck      (ck)
  );

  function automatic logic [3:0] bl_decode(input logic [2:0] f);
    case (f)
      3'h1:    bl_decode = 4'h2;
      3'h2:    bl_decode = 4'h4;
      3'h3:    bl_decode = 4'h8;
      default: bl_decode = 4'h2;
    endcase
  endfunction
  // Burst length field [RQ17]
  assign burst_len = bl_decode(mode_ff[MR_BL_LSB +: 3]);

  // ***********************************************************
  // Wishbone slave, one wait state
  // ***********************************************************
  logic wb_req;
  assign wb_req = I_WB_CYC && I_WB_STB && !O_WB_ACK;
  assign go = wb_req && I_WB_WE && I_WB_ADR == REG_CTRL
              && I_WB_SEL[0] && I_WB_DAT[CTRL_GO] && !busy_ff;

  always_ff @(posedge I_CLK)
  begin
    if (I_SYS_RST)
      O_WB_ACK <= 1'b0;
    else
      O_WB_ACK <= wb_req;
  end

  function automatic logic [31:0] lane_wr(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  sel);
    for (int i = 0; i < 4; i++)
      lane_wr[8*i +: 8] = sel[i] ? nw[8*i +: 8] : old[8*i +: 8];
  endfunction

  always_ff @(posedge I_CLK)
  begin
    if (I_SYS_RST)
    begin
      ctrl_ff  <= CTRL_RST_VAL;
      mode_ff  <= MODE_RST_VAL;
      addr_ff  <= 32'h0000_0000;
      wdata_ff <= 32'h0000_0000;
      wmask_ff <= 4'h0;
    end
    else if (wb_req && I_WB_WE)
    begin
      case (I_WB_ADR)
        REG_CTRL:  ctrl_ff  <= lane_wr(ctrl_ff, I_WB_DAT, I_WB_SEL)
                               & ~32'h0000_0001;
        REG_MODE:  mode_ff  <= lane_wr(mode_ff, I_WB_DAT, I_WB_SEL);
        REG_ADDR:  addr_ff  <= lane_wr(addr_ff, I_WB_DAT, I_WB_SEL);
        REG_WDATA: wdata_ff <= lane_wr(wdata_ff, I_WB_DAT, I_WB_SEL);
        REG_WMASK: if (I_WB_SEL[0]) wmask_ff <= I_WB_DAT[3:0];
        default:   ;
      endcase
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_SYS_RST)
      O_WB_DAT <= 32'h0000_0000;
    else if (wb_req && !I_WB_WE)
    begin
      case (I_WB_ADR)
        REG_CTRL:   O_WB_DAT <= ctrl_ff;
        REG_MODE:   O_WB_DAT <= mode_ff;
        REG_ADDR:   O_WB_DAT <= addr_ff;
        REG_WDATA:  O_WB_DAT <= wdata_ff;
        REG_RDATA:  O_WB_DAT <= rdata_ff;
        REG_STATUS: O_WB_DAT <= {28'h0, ref_pend_ff, err_ff,
                                 mrs_done_ff, busy_ff};
        REG_WMASK:  O_WB_DAT <= {28'h0, wmask_ff};
        default:    O_WB_DAT <= 32'h0000_0000;
      endcase
    end
  end

  // ***********************************************************
  // Refresh timer
  // ***********************************************************
  // Refresh waits for idle, so the timer fires with margin [RQ19]
  always_ff @(posedge I_CLK)
  begin
    if (I_SYS_RST)
    begin
      ref_cnt_ff  <= 16'h0000;
      ref_pend_ff <= 1'b0;
    end
    else
    begin
      if (ref_cnt_ff >= 16'(REFI - 2 * CMD_GAP_CYC * LINK_DIV))
      begin
        ref_cnt_ff  <= 16'h0000;
        ref_pend_ff <= ctrl_ff[CTRL_RFEN] && mrs_done_ff;
      end
      else
      begin
        ref_cnt_ff <= ref_cnt_ff + 16'h0001;
        if (state_ff == ST_CMD && op_ff == OP_REF && fall)
          ref_pend_ff <= 1'b0;
      end
    end
  end

  // ***********************************************************
  // Command sequencer
  // ***********************************************************
  always_ff @(posedge I_CLK)
  begin
    if (I_SYS_RST)
    begin
      state_ff    <= ST_IDLE;
      op_ff       <= OP_ACT;
      busy_ff     <= 1'b0;
      mrs_done_ff <= 1'b0;
      err_ff      <= 1'b0;
      wait_ff     <= 8'h00;
      beat_ff     <= 4'h0;
    end
    else
    begin
      case (state_ff)
        ST_IDLE:
        begin
          if (ref_pend_ff)
          begin
            op_ff    <= OP_REF;
            busy_ff  <= 1'b1;
            state_ff <= ST_CMD;
          end
          else if (go)
          begin
            // Access before mode set is refused [RQ15]
            if (!mrs_done_ff && I_WB_DAT[CTRL_CMD_LSB +: 3] != OP_MRS
                && I_WB_DAT[CTRL_CMD_LSB +: 3] != OP_PRE)
              err_ff <= 1'b1;
            else
            begin
              op_ff    <= I_WB_DAT[CTRL_CMD_LSB +: 3];
              busy_ff  <= 1'b1;
              state_ff <= ST_CMD;
            end
          end
        end
        ST_CMD:
          if (fall)
          begin
            if (op_ff == OP_MRS)
              mrs_done_ff <= 1'b1;
            // CL 3 vs 2.5 rounds up to whole link cycles [RQ16]
            wait_ff  <= (op_ff == OP_RD) ? 8'h03 : 8'(CMD_GAP_CYC);
            state_ff <= ST_WAIT;
          end
        ST_WAIT:
          if (rise)
          begin
            if (wait_ff == 8'h01)
            begin
              beat_ff  <= 4'h0;
              state_ff <= (op_ff == OP_RD || op_ff == OP_WR)
                          ? ST_DATA : ST_DONE;
            end
            wait_ff <= wait_ff - 8'h01;
          end
        ST_DATA:
          // Reads count captured strobes; writes run one beat on for strobe
          if (op_ff == OP_WR ? (rise || fall) : dqs_edge)
          begin
            beat_ff <= beat_ff + 4'h1;
            if (beat_ff == burst_len - ((op_ff == OP_WR) ? 4'h0 : 4'h1))
              state_ff <= ST_DONE;
          end
        ST_DONE:
        begin
          busy_ff  <= 1'b0;
          state_ff <= ST_IDLE;
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // ***********************************************************
  // Pin drivers
  // ***********************************************************
  // Commands change at the falling link edge, stable for the rise [RQ3]
  always_ff @(posedge I_CLK)
  begin
    if (I_SYS_RST)
    begin
      O_CK         <= 1'b0;
      O_CK_N       <= 1'b1;
      O_CLOCK_GATE <= 1'b0;
      O_RANK_SEL_N <= 1'b1;
      {O_RAS_N, O_CAS_N, O_WE_N} <= CMD_NOP;
      O_BA         <= 2'h0;
      O_A          <= 13'h0000;
    end
    else
    begin
      O_CK   <= ck ^ (rise | fall);              // [RQ21]
      O_CK_N <= ~(ck ^ (rise | fall));
      O_CLOCK_GATE <= ctrl_ff[CTRL_CKE];         // [RQ1]
      if (state_ff == ST_CMD && fall)
      begin
        O_RANK_SEL_N <= 1'b0;                    // [RQ2]
        O_BA <= addr_ff[29:28];                  // [RQ5]
        case (op_ff)                             // [RQ4] [RQ22]
          OP_ACT:
          begin
            {O_RAS_N, O_CAS_N, O_WE_N} <= CMD_ACT;
            O_A <= addr_ff[25:13];               // [RQ6]
          end
          OP_RD, OP_WR:
          begin
            {O_RAS_N, O_CAS_N, O_WE_N} <= (op_ff == OP_RD)
                                          ? CMD_RD : CMD_WR;
            // Column and auto-precharge flag [RQ7] [RQ8]
            O_A <= {2'h0, ctrl_ff[CTRL_AP], 1'b0, addr_ff[8:0]};
          end
          OP_PRE:
          begin
            {O_RAS_N, O_CAS_N, O_WE_N} <= CMD_PRE;
            // AP high closes all banks, else only BA [RQ9] [RQ10]
            O_A <= {2'h0, ctrl_ff[CTRL_AP], 10'h000};
          end
          OP_REF: {O_RAS_N, O_CAS_N, O_WE_N} <= CMD_REF;
          OP_MRS:
          begin
            {O_RAS_N, O_CAS_N, O_WE_N} <= CMD_MRS;
            O_BA <= 2'h0;
            // Burst length, type, latency [RQ15] [RQ17] [RQ18]
            O_A <= mode_ff[12:0];
          end
          default: {O_RANK_SEL_N, O_RAS_N, O_CAS_N, O_WE_N} <= {1'b1, CMD_NOP};
        endcase
      end
      else if (fall)
      begin
        O_RANK_SEL_N <= 1'b1;
        {O_RAS_N, O_CAS_N, O_WE_N} <= CMD_NOP;
      end
    end
  end

  // Write data: DQS edge lands mid-eye of each beat [RQ12] [RQ20]
  always_ff @(posedge I_CLK)
  begin
    if (I_SYS_RST)
    begin
      O_DQ     <= 8'h00;
      O_DQ_OE  <= 1'b0;
      O_DQS    <= 1'b0;
      O_DQS_OE <= 1'b0;
      O_DM     <= 1'b0;
    end
    else if (state_ff == ST_DATA && op_ff == OP_WR)
    begin
      O_DQ_OE  <= 1'b1;
      O_DQS_OE <= 1'b1;
      if (rise || fall)
      begin
        O_DQ <= wdata_ff[8*beat_ff[1:0] +: 8];
        O_DM <= wmask_ff[beat_ff[1:0]];          // [RQ13]
      end
      else if (beat_ff != 4'h0)
        O_DQS <= ~O_DQS;
    end
    else
    begin
      O_DQ_OE  <= 1'b0;
      O_DQS_OE <= 1'b0;
      O_DQS    <= 1'b0;
      O_DM     <= 1'b0;                          // [RQ14]
    end
  end

  // Read capture: strobe edges align with data edges [RQ11]
  assign dqs_edge = dq_sync_ff[1][1] != dq_sync_ff[1][0];
  always_ff @(posedge I_CLK)
  begin
    if (I_SYS_RST)
    begin
      dq_sync_ff[0] <= 2'h0;
      dq_sync_ff[1] <= 2'h0;
      dq_s1_ff      <= 8'h00;
      dq_s2_ff      <= 8'h00;
      rdata_ff      <= 32'h0000_0000;
    end
    else
    begin
      dq_sync_ff[0] <= {dq_sync_ff[0][0], I_DQS};
      dq_sync_ff[1] <= {dq_sync_ff[1][0], dq_sync_ff[0][1]};
      dq_s1_ff      <= I_DQ;
      dq_s2_ff      <= dq_s1_ff;
      if (state_ff == ST_DATA && op_ff == OP_RD && dqs_edge)
        rdata_ff <= {dq_s2_ff, rdata_ff[31:8]};
    end
  end
endmodule

/* File: tb/ddrh_ctrl_assertions.sv */
`timescale 1ns/100ps
module ddrh_chk
  import ddrh_pkg::*;
#(
  parameter int REFI = REFI_CYC
)(
  input wire logic        I_CLK,        // clock
  input wire logic        I_SYS_RST,    // reset
  input wire logic        I_WB_CYC,     // cycle
  input wire logic        I_WB_STB,     // strobe
  input wire logic        I_WB_WE,      // write
  input wire logic [7:0]  I_WB_ADR,     // address
  input wire logic [31:0] I_WB_DAT,     // write data
  input wire logic        O_WB_ACK,     // ack
  input wire logic        O_CK,         // link clock
  input wire logic        O_CK_N,       // complement
  input wire logic        O_CLOCK_GATE, // gate
  input wire logic        O_RANK_SEL_N, // select
  input wire logic        O_RAS_N,      // row strobe
  input wire logic        O_CAS_N,      // col strobe
  input wire logic        O_WE_N,       // write enable
  input wire logic [1:0]  O_BA,         // bank
  input wire logic [12:0] O_A,          // address
  input wire logic [7:0]  O_DQ,         // data
  input wire logic        O_DQ_OE,      // data enable
  input wire logic        O_DQS,        // strobe
  input wire logic        O_DQS_OE,     // strobe enable
  input wire logic        O_DM          // mask
);
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_SYS_RST);
  wire [2:0] cmd = {O_RAS_N, O_CAS_N, O_WE_N};
  // ************************************************
  // Sequences
  // ************************************************
  sequence s_req;
    I_WB_CYC && I_WB_STB && !O_WB_ACK;
  endsequence
  sequence s_ctrl_wr;
    I_WB_CYC && I_WB_STB && I_WB_WE && O_WB_ACK && I_WB_ADR == REG_CTRL;
  endsequence
  sequence s_cmd_start;
    $fell(O_RANK_SEL_N);
  endsequence
  // ************************************************
  // Properties
  // ************************************************
  property p_ack_pulse;
    O_WB_ACK |=> !O_WB_ACK;
  endproperty
  property p_ack_answer;
    s_req |=> O_WB_ACK;
  endproperty
  property p_ck_pair;
    O_CK != O_CK_N;
  endproperty
  // Pins only move with the falling link edge, so rising edge sees them set
  property p_cmd_at_fall;
    !$stable({O_RANK_SEL_N, cmd, O_BA, O_A}) |-> $fell(O_CK);
  endproperty
  property p_cmd_one_link;
    s_cmd_start |-> !O_RANK_SEL_N [*4] ##1 O_RANK_SEL_N;
  endproperty
  property p_nop_idle;
    O_RANK_SEL_N |-> cmd == CMD_NOP;
  endproperty
  property p_cmd_real;
    !O_RANK_SEL_N |-> cmd != CMD_NOP;
  endproperty
  property p_gate;
    s_ctrl_wr ##0 I_WB_DAT[CTRL_CKE] |-> ##[0:3] O_CLOCK_GATE;
  endproperty
  property p_dq_with_dqs;
    O_DQ_OE |-> O_DQS_OE;
  endproperty
  property p_mid_eye;
    O_DQS_OE && $past(O_DQS_OE) && !$stable(O_DQS) |->
      $stable(O_DQ) && $stable(O_DM);
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack held too long");
  a_ack_answer: assert property (p_ack_answer)
    else $error("ack missing");
  a_ck_pair: assert property (p_ck_pair)
    else $error("clock pair not complementary");
  a_cmd_at_fall: assert property (p_cmd_at_fall)
    else $error("command pins moved off falling edge");
  a_cmd_one_link: assert property (p_cmd_one_link)
    else $error("command not one link cycle");
  a_nop_idle: assert property (p_nop_idle)
    else $error("deselected pins not idle");
  a_cmd_real: assert property (p_cmd_real)
    else $error("selected idle code");
  a_gate: assert property (p_gate)
    else $error("gate did not follow control");
  a_dq_with_dqs: assert property (p_dq_with_dqs)
    else $error("data driven without strobe");
  a_mid_eye: assert property (p_mid_eye)
    else $error("strobe edge on data change");
endmodule
bind ddrh_ctrl ddrh_chk #(.REFI(REFI)) i_chk (
  .I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .I_WB_CYC(I_WB_CYC),
  .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR),
  .I_WB_DAT(I_WB_DAT), .O_WB_ACK(O_WB_ACK), .O_CK(O_CK), .O_CK_N(O_CK_N),
  .O_CLOCK_GATE(O_CLOCK_GATE), .O_RANK_SEL_N(O_RANK_SEL_N),
  .O_RAS_N(O_RAS_N), .O_CAS_N(O_CAS_N), .O_WE_N(O_WE_N), .O_BA(O_BA),
  .O_A(O_A), .O_DQ(O_DQ), .O_DQ_OE(O_DQ_OE), .O_DQS(O_DQS),
  .O_DQS_OE(O_DQS_OE), .O_DM(O_DM));

/* File: tb/ddrh_dev_model.sv */
`timescale 1ns/100ps
module ddrh_dev_model
  import ddrh_pkg::*;
(
  input  wire logic        i_ck,     // link clock
  input  wire logic        i_gate,   // clock gate
  input  wire logic        i_rank_n, // select
  input  wire logic [2:0]  i_cmd,    // ras cas we
  input  wire logic [1:0]  i_ba,     // bank
  input  wire logic [12:0] i_a,      // address
  input  wire logic [7:0]  i_dq,     // data wire
  input  wire logic        i_dqs,    // strobe wire
  input  wire logic        i_wr_en,  // host drives strobe
  input  wire logic        i_dm,     // mask
  output logic      [7:0]  o_dq,     // read data
  output logic             o_dqs     // read strobe
);
  logic [12:0] mode_ff = 13'h0;
  logic [3:0]  open_ff = 4'h0;
  logic [12:0] row_ff [4];
  logic [7:0]  mem [int];
  int          cmd_cnt = 0;
  int          ref_cnt = 0;
  int          wbeat = 99;
  logic [1:0]  wba;
  logic [8:0]  wcol;
  logic        wap;
  initial
  begin
    o_dq = 8'h5a;
    o_dqs = 1'b0;
  end
  function automatic int key(logic [1:0] ba, logic [8:0] c, int i);
    int bl;
    bl = 1 << mode_ff[2:0];
    return {ba, row_ff[ba], mode_ff[3] ? c ^ 9'(i) :
      9'((c & ~(bl - 1)) | ((c + i) & (bl - 1)))};
  endfunction
  task automatic rd_burst(logic [1:0] ba, logic [8:0] c, logic ap);
    logic [7:0] b;
    if (mode_ff[6:4] == 3'h6)
    begin
      repeat (2) @(posedge i_ck);
      @(negedge i_ck);
    end
    else
      repeat (3) @(posedge i_ck);
    for (int i = 0; i < (1 << mode_ff[2:0]); i++)
    begin
      b = mem.exists(key(ba, c, i)) ? mem[key(ba, c, i)] : 8'h00;
      o_dq = b;
      o_dqs = ~i[0];
      @(i_ck);
    end
    // Released lines show no stale value
    o_dq = ~b;
    o_dqs = 1'b0;
    if (ap) open_ff[ba] = 1'b0;
  endtask
  always @(posedge i_ck)
    if (i_gate && !i_rank_n)
    begin
      cmd_cnt++;
      case (i_cmd)
        CMD_MRS: mode_ff = i_a;
        CMD_ACT:
        begin
          open_ff[i_ba] = 1'b1;
          row_ff[i_ba] = i_a;
        end
        CMD_PRE:
          if (i_a[10]) open_ff = 4'h0;
          else open_ff[i_ba] = 1'b0;
        CMD_REF: ref_cnt++;
        CMD_RD: fork rd_burst(i_ba, i_a[8:0], i_a[10]); join_none
        CMD_WR:
        begin
          wba = i_ba;
          wcol = i_a[8:0];
          wap = i_a[10];
          wbeat = 0;
        end
        default: ;
      endcase
    end
  always @(i_dqs)
    if (i_wr_en && wbeat < (1 << mode_ff[2:0]))
    begin
      if (!i_dm) mem[key(wba, wcol, wbeat)] = i_dq;
      wbeat++;
      if (wap && wbeat == (1 << mode_ff[2:0])) open_ff[wba] = 1'b0;
    end
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/100ps
module tb_top
  import ddrh_pkg::*;
;
  localparam int REFI_SIM = 200;
  typedef struct {
    logic we; logic [7:0] adr; logic [31:0] dat; logic [31:0] exp;
  } ddrh_row_s;
  ddrh_row_s rows [9] = '{
    '{0, REG_CTRL, 0, CTRL_RST_VAL}, '{0, REG_MODE, 0, MODE_RST_VAL},
    '{0, REG_STATUS, 0, 0}, '{1, 8'h1c, 32'hffff_ffff, 0},
    '{0, 8'h1c, 0, 0}, '{1, REG_ADDR, 32'h2345_6089, 0},
    '{0, REG_ADDR, 0, 32'h2345_6089}, '{1, REG_WDATA, 32'hcafe_f00d, 0},
    '{0, REG_WDATA, 0, 32'hcafe_f00d}};
  logic [31:0] modes [3] = '{32'h31, 32'h6b, 32'h32};
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0;
  logic [7:0]  adr = 0;
  logic [3:0]  sel = 4'hf;
  logic [31:0] wdat = 0, wb_dat, rd, ctl_base = 0;
  logic ack, ck, ck_n, gate, rank_n, ras_n, cas_n, we_n, dq_oe, dqs_o;
  logic dqs_oe, dm, m_dqs;
  logic [1:0]  ba;
  logic [12:0] a;
  logic [7:0]  dq_o, m_dq;
  int mismatches = 0, checks_done = 0, n;
  wire [7:0] dq_w = dq_oe ? dq_o : m_dq;
  wire       dqs_w = dqs_oe ? dqs_o : m_dqs;
  initial
  begin
    forever #2 clk = ~clk;
  end
  ddrh_ctrl #(.REFI(REFI_SIM)) i_dut (
    .I_CLK(clk), .I_SYS_RST(rst), .I_WB_CYC(cyc), .I_WB_STB(stb),
    .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat),
    .O_WB_DAT(wb_dat), .O_WB_ACK(ack), .O_CK(ck), .O_CK_N(ck_n),
    .O_CLOCK_GATE(gate), .O_RANK_SEL_N(rank_n), .O_RAS_N(ras_n),
    .O_CAS_N(cas_n), .O_WE_N(we_n), .O_BA(ba), .O_A(a), .O_DQ(dq_o),
    .O_DQ_OE(dq_oe), .I_DQ(dq_w), .O_DQS(dqs_o), .O_DQS_OE(dqs_oe),
    .I_DQS(dqs_w), .O_DM(dm));
  ddrh_dev_model i_dev (
    .i_ck(ck), .i_gate(gate), .i_rank_n(rank_n),
    .i_cmd({ras_n, cas_n, we_n}), .i_ba(ba), .i_a(a), .i_dq(dq_w),
    .i_dqs(dqs_w), .i_wr_en(dqs_oe), .i_dm(dm), .o_dq(m_dq), .o_dqs(m_dqs));
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb(logic w, logic [7:0] ad, logic [31:0] d);
    @(posedge clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= ad;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    rd = wb_dat;
    cyc <= 0;
    stb <= 0;
    we <= 0;
  endtask
  task automatic go(logic [2:0] op, logic ap);
    wb(1, REG_CTRL, ctl_base | 32'({ap, op, 1'b1}));
    do wb(0, REG_STATUS, 0); while (rd[0] !== 1'b0);
  endtask
  task automatic at(logic [1:0] b, logic [12:0] r, logic [8:0] c);
    wb(1, REG_ADDR, {2'b0, b, 2'b0, r, 4'h0, c});
  endtask
  task automatic tally_and_finish;
    if (mismatches == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (30000) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    chk(32'({a, ba, ack, ck, ck_n, gate, rank_n, ras_n, cas_n, we_n}),
      32'h2f);
    foreach (rows[i])
    begin
      wb(rows[i].we, rows[i].adr, rows[i].dat);
      if (!rows[i].we) chk(rd, rows[i].exp);
    end
    ctl_base = 32'h20;
    wb(1, REG_CTRL, ctl_base);
    repeat (4) @(posedge clk);
    chk(32'(gate), 1);
    // Access before mode programming must stay off the pins
    n = i_dev.cmd_cnt;
    go(OP_RD, 0);
    chk(i_dev.cmd_cnt, n);
    chk(32'(rd[2]), 1);
    foreach (modes[i])
    begin
      wb(1, REG_MODE, modes[i]);
      go(OP_MRS, 0);
      chk(32'(i_dev.mode_ff), modes[i]);
    end
    at(2'h2, 13'h0abc, 9'h4);
    go(OP_ACT, 0);
    chk(32'({i_dev.open_ff, i_dev.row_ff[2]}), 32'h8abc);
    wb(1, REG_WDATA, 32'h4433_2211);
    wb(1, REG_WMASK, 0);
    go(OP_WR, 0);
    wb(1, REG_WDATA, 32'hddcc_bbaa);
    wb(1, REG_WMASK, 32'h4);
    go(OP_WR, 0);
    chk(32'(i_dev.mem[{2'h2, 13'h0abc, 9'h4}]), 32'haa);
    wb(1, REG_WMASK, 32'hf);
    go(OP_RD, 1);
    wb(0, REG_RDATA, 0);
    chk(rd, 32'hdd33_bbaa);
    chk(32'(i_dev.open_ff), 0);
    wb(1, REG_MODE, 32'h6a);
    go(OP_MRS, 0);
    at(2'h1, 13'h5, 9'h1);
    go(OP_ACT, 0);
    wb(1, REG_WDATA, 32'h0403_0201);
    wb(1, REG_WMASK, 0);
    go(OP_WR, 0);
    chk(32'(i_dev.mem[{2'h1, 13'h5, 9'h0}]), 32'h02);
    go(OP_RD, 0);
    wb(0, REG_RDATA, 0);
    chk(rd, 32'h0403_0201);
    at(2'h3, 13'h7, 9'h0);
    go(OP_ACT, 0);
    at(2'h1, 13'h0, 9'h0);
    go(OP_PRE, 0);
    chk(32'(i_dev.open_ff), 32'h8);
    at(2'h0, 13'h0, 9'h0);
    go(OP_PRE, 1);
    chk(32'(i_dev.open_ff), 0);
    ctl_base = 32'h60;
    wb(1, REG_CTRL, ctl_base);
    n = i_dev.ref_cnt;
    repeat (3 * REFI_SIM) @(posedge clk);
    chk(32'(i_dev.ref_cnt - n >= 2), 1);
    tally_and_finish();
  end
endmodule
